// file: hw/rsq_top.sv
// Reset sequencer: power-on timing, hard-reset qualifier, reset stretchers
// Notes on behaviour
// - Internal power-on reset stays asserted exactly 300 ms of 32 kHz cycles.
// - SDRAM controller reset is stretched to exactly 7 low-frequency cycles.
// - System reset and reset pin are stretched to exactly 14 cycles.
// - Hard reset is accepted after 4 consecutive asserted low-frequency cycles.
module rsq_top
  import rsq_pkg::*;
#(
  parameter int POR_CYCLES = POR_LF_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic por_n_i,
  input wire logic hard_rst_n_i,
  output rsq_resets_type resets_o,
  output logic rst_pin_n_o,
  output logic por_active_o
);
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

  logic por_sync_n, hard_sync_n, por_in_act, hard_act;

  // Pin inputs cross into the clock domain before any counter sees them
  rsq_sync #(.RST_VAL(1'b0)) u_sync_por (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i(por_n_i),
    .level_o(por_sync_n)
  );

  rsq_sync #(.RST_VAL(1'b1)) u_sync_hard (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i(hard_rst_n_i),
    .level_o(hard_sync_n)
  );

  assign por_in_act = ~por_sync_n;
  assign hard_act = ~hard_sync_n;

  // Low-frequency tick divider
  logic [DIV_W-1:0] div_q, div_d;
  logic tick;

  // 25 MHz does not divide evenly; 781 gives 32.01 kHz, close enough
  always_comb begin
    tick = (div_q == DIV_LAST);
    div_d = tick ? DIV_RST : div_q + DIV_W'(1);
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      div_q <= DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // Power-on sequencer
  rsq_por_state_type state_q, state_d;
  logic [POR_CNT_W-1:0] pcnt_q, pcnt_d;
  logic por_int;

  // Timing restarts whenever the input is reasserted mid-count
  always_comb begin
    state_d = state_q;
    pcnt_d = pcnt_q;
    unique case (state_q)
      POR_HOLD: begin
        pcnt_d = POR_CNT_RST;
        if (!por_in_act) begin
          state_d = POR_TIMING;
        end
      end
      POR_TIMING: begin
        if (por_in_act) begin
          state_d = POR_HOLD;
        end else if (tick) begin
          if (pcnt_q == POR_LAST) begin
            state_d = POR_DONE;
          end else begin
            pcnt_d = pcnt_q + POR_CNT_W'(1);
          end
        end
      end
      POR_DONE: begin
        if (por_in_act) begin
          state_d = POR_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= POR_HOLD;
      pcnt_q <= POR_CNT_RST;
    end else begin
      state_q <= state_d;
      pcnt_q <= pcnt_d;
    end
  end

  assign por_int = (state_q != POR_DONE);

  // Hard-reset qualifier: saturates at the qualify length, any gap clears it
  logic [QUAL_W-1:0] qcnt_q, qcnt_d;
  logic hard_qual;

  always_comb begin
    qcnt_d = qcnt_q;
    if (!hard_act) begin
      qcnt_d = QUAL_CNT_RST;
    end else if (tick && qcnt_q != HR_QUAL_CYCLES) begin
      qcnt_d = qcnt_q + QUAL_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      qcnt_q <= QUAL_CNT_RST;
    end else begin
      qcnt_q <= qcnt_d;
    end
  end

  assign hard_qual = (qcnt_q == HR_QUAL_CYCLES);

  // Stretchers reload while a source is active, then run down on ticks
  logic src;
  logic [STR_W-1:0] sd_q, sd_d, sy_q, sy_d;
  rsq_resets_type out_q, out_d;

  assign src = por_int | hard_qual;

  always_comb begin
    sd_d = sd_q;
    sy_d = sy_q;
    if (src) begin
      sd_d = SDRAM_LF_CYCLES;
      sy_d = SYS_LF_CYCLES;
    end else if (tick) begin
      if (sd_q != STR_CNT_RST) begin
        sd_d = sd_q - STR_W'(1);
      end
      if (sy_q != STR_CNT_RST) begin
        sy_d = sy_q - STR_W'(1);
      end
    end
    out_d.sdram_rst = src | (sd_q != STR_CNT_RST);
    out_d.internal_system_reset = src | (sy_q != STR_CNT_RST);
  end

  // Reset outputs come straight from flops so no glitch leaves the block; por_active_o is decoded from state_q
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sd_q <= SDRAM_LF_CYCLES;
      sy_q <= SYS_LF_CYCLES;
      out_q <= RESETS_RST;
    end else begin
      sd_q <= sd_d;
      sy_q <= sy_d;
      out_q <= out_d;
    end
  end

  assign resets_o = out_q;
  assign rst_pin_n_o = ~out_q.internal_system_reset;
  assign por_active_o = por_int;

  // Checking helpers: ticks counted independently of the design counters
  logic [POR_CNT_W-1:0] chk_por_q;
  logic [STR_W-1:0] chk_sd_q, chk_sy_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || state_q != POR_TIMING) begin
      chk_por_q <= POR_CNT_RST;
    end else if (tick) begin
      chk_por_q <= chk_por_q + POR_CNT_W'(1);
    end
    if (srst_i || src) begin
      chk_sd_q <= STR_CNT_RST;
      chk_sy_q <= STR_CNT_RST;
    end else if (tick) begin
      chk_sd_q <= chk_sd_q + STR_W'(1);
      chk_sy_q <= chk_sy_q + STR_W'(1);
    end
  end

  a_por_width: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    (state_q == POR_DONE && $past(state_q) == POR_TIMING)
      |-> $past(chk_por_q) == POR_LAST && $past(tick))
    else $error("internal power-on reset released at wrong count");

  a_sdram_stretch: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    $fell(out_q.sdram_rst) |-> chk_sd_q == SDRAM_LF_CYCLES)
    else $error("sdram reset stretch length wrong");

  a_sys_stretch: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    $fell(out_q.internal_system_reset) |-> chk_sy_q == SYS_LF_CYCLES)
    else $error("system reset stretch length wrong");

  // An active source must show on both resets one edge later
  a_src_asserts: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    src |=> out_q.sdram_rst && out_q.internal_system_reset)
    else $error("reset outputs not following source");

  // The pin is let go only once the long stretch has run out
  a_pin_release: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    $rose(rst_pin_n_o) |-> chk_sy_q == SYS_LF_CYCLES)
    else $error("reset pin released at wrong count");

  a_qual_length: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    $rose(hard_qual) |-> $past(tick) && $past(hard_act)
      && $past(qcnt_q) == HR_QUAL_CYCLES - QUAL_W'(1))
    else $error("hard reset qualified without full run");

  // Any gap in the request drops the qualified level at the next edge
  a_qual_clear: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    hard_qual && !hard_act |=> !hard_qual)
    else $error("hard reset stayed qualified after a gap");
endmodule

// file: hw/rsq_pkg.sv
// Shared constants and types for the reset stretch qualifier
package rsq_pkg;
  // System clock and derived low-frequency tick
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int LF_CLK_HZ = 32_000;
  localparam int LF_DIV = SYS_CLK_HZ / LF_CLK_HZ;
  localparam int DIV_W = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LF_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_RST = 10'h000;

  // Internal power-on reset width, in ms and in low-frequency cycles
  localparam int POR_TIME_MS = 300;
  localparam int POR_LF_CYCLES = POR_TIME_MS * (LF_CLK_HZ / 1000);
  localparam int POR_CNT_W = 14;
  localparam logic [POR_CNT_W-1:0] POR_CNT_RST = 14'h0000;

  // Minimum width of the external power-on reset input, far side only
  localparam int POR_IN_MIN_MS = 800;

  // Stretcher lengths in low-frequency cycles
  localparam int STR_W = 4;
  localparam logic [STR_W-1:0] SDRAM_LF_CYCLES = 4'h7;
  localparam logic [STR_W-1:0] SYS_LF_CYCLES = 4'hE;
  localparam logic [STR_W-1:0] STR_CNT_RST = 4'h0;

  // Hard-reset qualifier length and far-side minimum width
  localparam int QUAL_W = 3;
  localparam logic [QUAL_W-1:0] HR_QUAL_CYCLES = 3'h4;
  localparam logic [QUAL_W-1:0] QUAL_CNT_RST = 3'h0;
  localparam int HR_MIN_CYCLES = 4;

  // Power-on reset sequencing states
  typedef enum logic [1:0] {
    POR_HOLD,
    POR_TIMING,
    POR_DONE
  } rsq_por_state_type;

  // Reset outputs delivered inside the chip, active high
  typedef struct packed {
    logic sdram_rst;
    logic internal_system_reset;
  } rsq_resets_type;

  localparam rsq_resets_type RESETS_RST = 2'h3;
endpackage

// file: hw/rsq_sync.sv
// Three-flop pin synchroniser with agreement filter
module rsq_sync
  import rsq_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;

  // First stage feeds only the second; level moves once stages 2 and 3 agree
  always_comb begin
    s1_d = async_i;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // Register stage
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;

  // Output only follows a value that two late stages agreed on
  a_sync_agree: assert property (@(posedge ref_clk_i)
    disable iff (srst_i)
    $changed(lvl_q) |-> $past(s2_q) == $past(s3_q) && lvl_q == $past(s3_q))
    else $error("synchroniser output moved without agreement");
endmodule

// file: testbench/rsq_board.sv
// Board-side model of the power-on and hard-reset circuitry
module rsq_board (
  input wire logic ref_clk_i,
  output logic por_n_o,
  output logic hard_rst_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Power is still ramping at time zero, no hard reset pending
  initial begin
    por_n_o = 1'b0;
    hard_rst_n_o = 1'b1;
  end

  // Hold the power-on pin low, scaled down to keep the run short
  task automatic power_on(input int lo);
    por_n_o <= 1'b0;
    repeat (lo) @(posedge ref_clk_i);
    por_n_o <= 1'b1;
  endtask

  // Hard-reset pulse; a short one is only sent on purpose
  task automatic hard_reset(input int lo);
    hard_rst_n_o <= 1'b0;
    repeat (lo) @(posedge ref_clk_i);
    hard_rst_n_o <= 1'b1;
  endtask
endmodule

// file: testbench/rsq_top_tb.sv
// Self-checking bench for the reset sequencer
module rsq_top_tb
  import rsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 20;
  localparam int TK = LF_DIV;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic por_n;
  logic hr_n;
  rsq_resets_type rs;
  logic pin_n;
  logic por_act;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int m;

  // 25 MHz clock
  always #20 ref_clk_i = ~ref_clk_i;

  rsq_top #(.POR_CYCLES(PC)) rsq_top_i (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .por_n_i(por_n),
    .hard_rst_n_i(hr_n),
    .resets_o(rs),
    .rst_pin_n_o(pin_n),
    .por_active_o(por_act)
  );

  rsq_board rsq_board_i (
    .ref_clk_i(ref_clk_i),
    .por_n_o(por_n),
    .hard_rst_n_o(hr_n)
  );

  task automatic finish_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, ceiling well above the roughly 67k cycles needed
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch %0t got %0h exp %0h..%0h", $time, got, lo, hi);
    end
  endtask

  task automatic chk_val(input logic [3:0] exp);
    checks_done++;
    if ({rs, pin_n, por_act} !== exp) begin
      n_mismatch++;
      $display("mismatch %0t got %0h exp %0h", $time,
               {rs, pin_n, por_act}, exp);
    end
  endtask

  // Edges until one output reaches a level; returns lim if it never does
  task automatic wait_out(input int sel, input logic v, input int lim,
                          output int k);
    logic s;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      k++;
      s = sel == 0 ? rs.sdram_rst :
          sel == 1 ? rs.internal_system_reset : por_act;
    end while (s !== v && k < lim);
  endtask

  task automatic t_reset;
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk_val(4'hD);
  endtask

  // Power-on timing, then the SDRAM stretch counted from its end and the system stretch from the SDRAM release
  task automatic t_por;
    @(posedge ref_clk_i);
    rsq_board_i.power_on(3 * TK);
    wait_out(2, 1'b0, 30 * TK, n);
    chk_range(n, (PC - 1) * TK, PC * TK + 10);
    wait_out(0, 1'b0, 9 * TK, n);
    chk_range(n, 7 * TK - 2, 7 * TK + 2);
    wait_out(1, 1'b0, 9 * TK, n);
    chk_range(n, 7 * TK - 2, 7 * TK + 2);
    #1 chk_val(4'h2);
  endtask

  // Three tick periods can hold at most three ticks, so this must be ignored
  task automatic t_hr_short;
    @(posedge ref_clk_i);
    fork
      rsq_board_i.hard_reset(3 * TK);
    join_none
    wait_out(0, 1'b1, 4 * TK + 20, n);
    chk_range(n, 4 * TK + 20, 4 * TK + 20);
  endtask

  // A valid pulse is qualified, then stretched 7 and 14 ticks
  task automatic t_hr_ok;
    @(posedge ref_clk_i);
    fork
      rsq_board_i.hard_reset(5 * TK);
    join_none
    wait_out(0, 1'b1, 5 * TK, n);
    chk_range(n, 3 * TK, 4 * TK + 10);
    #1 chk_val(4'hC);
    wait_out(0, 1'b0, 9 * TK, m);
    chk_range(n + m, 11 * TK, 12 * TK + 12);
    wait_out(1, 1'b0, 9 * TK, n);
    chk_range(n, 7 * TK - 2, 7 * TK + 2);
    #1 chk_val(4'h2);
  endtask

  // Power-on input taken again: resets return, a mid-count drop restarts
  task automatic t_por_restart;
    @(posedge ref_clk_i);
    rsq_board_i.power_on(TK);
    #1 chk_val(4'hD);
    repeat (3 * TK) @(posedge ref_clk_i);
    #1 chk_val(4'hD);
    @(posedge ref_clk_i);
    rsq_board_i.power_on(TK);
    wait_out(2, 1'b0, 30 * TK, n);
    chk_range(n, (PC - 1) * TK, PC * TK + 10);
    #1 chk_val(4'hC);
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_por();
    t_hr_short();
    t_hr_ok();
    t_por_restart();
    finish_test();
  end
endmodule
